/* File: dsfl_regs.svh */
`ifndef DSFL_REGS_SVH
`define DSFL_REGS_SVH

// serial frame layout
`define DSFL_FRAME_BITS 16
`define DSFL_CNT_W 5
`define DSFL_CODE_W 10
`define DSFL_SEL_HI 15
`define DSFL_SEL_LO 14
`define DSFL_MODE_HI 13
`define DSFL_MODE_LO 12
`define DSFL_DATA_HI 11
`define DSFL_DATA_LO 2

// channel select field values
`define DSFL_SEL_A 2'h0
`define DSFL_SEL_B 2'h1

// register byte offsets
`define DSFL_OFS_CTRL 8'h00
`define DSFL_OFS_STATUS 8'h04
`define DSFL_OFS_OUT_A 8'h08
`define DSFL_OFS_OUT_B 8'h0C
`define DSFL_OFS_IN_A 8'h10
`define DSFL_OFS_IN_B 8'h14
`define DSFL_OFS_LAST 8'h18
`define DSFL_OFS_FRAMES 8'h1C
`define DSFL_OFS_ABORTS 8'h20

// control bits and reset values
`define DSFL_CTRL_EN_BIT 0
`define DSFL_CTRL_RESET 1'h1
`define DSFL_CODE_RESET 10'h000
`define DSFL_CNT_RESET 16'h0000

// status bit positions
`define DSFL_ST_PD_BIT 0
`define DSFL_ST_TERM_LO 1
`define DSFL_ST_TERM_HI 2
`define DSFL_ST_VALID_BIT 3
`define DSFL_ST_EN_BIT 4

// crossing depth in hclk cycles
`define DSFL_SYNC_STAGES 2

`endif

/* File: dsfl_pkg.sv */
package dsfl_pkg;

   typedef enum logic [1:0] {
      DSFL_MODE_LOAD = 2'h0,
      DSFL_MODE_LOAD_UPD = 2'h1,
      DSFL_MODE_BOTH = 2'h2,
      DSFL_MODE_PDOWN = 2'h3
   } dsfl_mode_e;

   typedef enum logic [1:0] {
      DSFL_TERM_NONE = 2'h0,
      DSFL_TERM_1K = 2'h1,
      DSFL_TERM_100K = 2'h2,
      DSFL_TERM_HIZ = 2'h3
   } dsfl_term_e;

   typedef logic [9:0] dsfl_code_t;
   typedef logic [15:0] dsfl_word_t;

endpackage

/* File: dsfl_frame_rx.sv */
`include "dsfl_regs.svh"

module dsfl_frame_rx
   import dsfl_pkg::*;
(
   input wire logic sclk,
   input wire logic hresetn,
   input wire logic sync_n,
   input wire logic din,
   output dsfl_word_t word_r,
   output logic commit_tgl_r,
   output logic abort_tgl_r
);

   logic [`DSFL_CNT_W-1:0] cnt_r;
   logic [`DSFL_FRAME_BITS-2:0] shift_r;
   logic partial_r;
   logic frame_clr_n;
   logic frame_on;

   // a high strobe wipes the partial frame at once, no clock edge needed
   assign frame_clr_n = hresetn & ~sync_n;
   assign frame_on = ~sync_n;

   always_ff @(negedge sclk or negedge frame_clr_n) begin
      if (!frame_clr_n) begin
         cnt_r <= 5'h00;
         shift_r <= 15'h0000;
      end else if (cnt_r != 5'h10) begin
         shift_r <= {shift_r[`DSFL_FRAME_BITS-3:0], din};
         cnt_r <= cnt_r + 5'h01;
      end
   end

   // word and toggles survive the strobe; only power-on clears them
   always_ff @(negedge sclk or negedge hresetn) begin
      if (!hresetn) begin
         word_r <= 16'h0000;
         commit_tgl_r <= 1'b0;
      end else if (frame_on && cnt_r == 5'h0F) begin
         word_r <= {shift_r, din};
         commit_tgl_r <= ~commit_tgl_r;
      end
   end

   // an unfinished frame is reported at the first edge of the next one
   always_ff @(negedge sclk or negedge hresetn) begin
      if (!hresetn) begin
         partial_r <= 1'b0;
         abort_tgl_r <= 1'b0;
      end else if (frame_on && cnt_r == 5'h00) begin
         partial_r <= 1'b1;
         if (partial_r) begin
            abort_tgl_r <= ~abort_tgl_r;
         end
      end else if (frame_on && cnt_r == 5'h0F) begin
         partial_r <= 1'b0;
      end
   end

endmodule // dsfl_frame_rx

/* File: dsfl_top.sv */
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`include "dsfl_regs.svh"

// Summary of operation
// - data bits are shifted into a 16-bit register on falling serial clock edges
// - shifting happens only while the frame strobe stays low
// - the sixteenth falling edge commits the word and updates the chosen channel
// - strobe raised early throws the partial word away, nothing changes
// - both output codes are zero from power-on until a valid word lands
// - each word holds channel select, mode, power-down choice and sample data
// - mode bits pick simultaneous update of both channels or one channel alone
// - power-down command with three termination choices while powered down
// - two independent 10-bit codes, channel A and channel B
module dsfl_top
   import dsfl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic din,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output dsfl_code_t channel_a_output,
   output dsfl_code_t channel_b_output,
   output logic power_down,
   output dsfl_term_e term_sel
);

   // serial side
   dsfl_word_t link_word;
   logic link_commit_tgl;
   logic link_abort_tgl;

   dsfl_frame_rx u_rx (
      .sclk(sclk),
      .hresetn(hresetn),
      .sync_n(sync_n),
      .din(din),
      .word_r(link_word),
      .commit_tgl_r(link_commit_tgl),
      .abort_tgl_r(link_abort_tgl)
   );

   // crossing into hclk
   logic commit_s1_r;
   logic commit_s2_r;
   logic commit_s3_r;
   logic abort_s1_r;
   logic abort_s2_r;
   logic abort_s3_r;
   logic commit_evt;
   logic abort_evt;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         commit_s1_r <= 1'b0;
         commit_s2_r <= 1'b0;
         commit_s3_r <= 1'b0;
      end else begin
         commit_s1_r <= link_commit_tgl;
         commit_s2_r <= commit_s1_r;
         commit_s3_r <= commit_s2_r;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         abort_s1_r <= 1'b0;
         abort_s2_r <= 1'b0;
         abort_s3_r <= 1'b0;
      end else begin
         abort_s1_r <= link_abort_tgl;
         abort_s2_r <= abort_s1_r;
         abort_s3_r <= abort_s2_r;
      end
   end

   assign commit_evt = commit_s2_r ^ commit_s3_r;
   assign abort_evt = abort_s2_r ^ abort_s3_r;

   // word decode
   function automatic dsfl_mode_e word_mode(input dsfl_word_t w);
      word_mode = dsfl_mode_e'(w[`DSFL_MODE_HI:`DSFL_MODE_LO]);
   endfunction

   function automatic logic [1:0] word_sel(input dsfl_word_t w);
      word_sel = w[`DSFL_SEL_HI:`DSFL_SEL_LO];
   endfunction

   // a power-down word with termination 0 or a single-channel word with a bad channel select is not valid
   function automatic logic word_valid(input dsfl_word_t w);
      if (word_mode(w) == DSFL_MODE_PDOWN) begin
         word_valid = (word_sel(w) != 2'h0);
      end else if (word_mode(w) == DSFL_MODE_BOTH) begin
         word_valid = 1'b1;
      end else begin
         word_valid = (word_sel(w) == `DSFL_SEL_A) || (word_sel(w) == `DSFL_SEL_B);
      end
   endfunction

   logic ctrl_en_r;
   dsfl_word_t last_word_r;
   logic apply;
   dsfl_mode_e cmd_mode;
   logic [1:0] cmd_sel;
   dsfl_code_t cmd_data;

   // the link word stands still for many hclk cycles after its toggle arrives
   assign cmd_mode = word_mode(link_word);
   assign cmd_sel = word_sel(link_word);
   assign cmd_data = link_word[`DSFL_DATA_HI:`DSFL_DATA_LO];
   assign apply = commit_evt && ctrl_en_r && word_valid(link_word);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_word_r <= 16'h0000;
      end else if (commit_evt) begin
         last_word_r <= link_word;
      end
   end

   // channel codes
   dsfl_code_t in_a_r;
   dsfl_code_t in_b_r;
   logic valid_seen_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_a_r <= `DSFL_CODE_RESET;
      end else if (apply) begin
         case (cmd_mode)
            DSFL_MODE_LOAD, DSFL_MODE_LOAD_UPD: begin
               if (cmd_sel == `DSFL_SEL_A) begin
                  in_a_r <= cmd_data;
               end
            end
            DSFL_MODE_BOTH: begin
               in_a_r <= cmd_data;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_b_r <= `DSFL_CODE_RESET;
      end else if (apply) begin
         case (cmd_mode)
            DSFL_MODE_LOAD, DSFL_MODE_LOAD_UPD: begin
               if (cmd_sel == `DSFL_SEL_B) begin
                  in_b_r <= cmd_data;
               end
            end
            DSFL_MODE_BOTH: begin
               in_b_r <= cmd_data;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         channel_a_output <= `DSFL_CODE_RESET;
      end else if (apply) begin
         case (cmd_mode)
            DSFL_MODE_LOAD_UPD: begin
               if (cmd_sel == `DSFL_SEL_A) begin
                  channel_a_output <= cmd_data;
               end
            end
            DSFL_MODE_BOTH: begin
               // both channels take the word on the same edge so they move together
               channel_a_output <= cmd_data;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         channel_b_output <= `DSFL_CODE_RESET;
      end else if (apply) begin
         case (cmd_mode)
            DSFL_MODE_LOAD_UPD: begin
               if (cmd_sel == `DSFL_SEL_B) begin
                  channel_b_output <= cmd_data;
               end
            end
            DSFL_MODE_BOTH: begin
               channel_b_output <= cmd_data;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         valid_seen_r <= 1'b0;
      end else if (apply) begin
         valid_seen_r <= 1'b1;
      end
   end

   // power-down
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         power_down <= 1'b0;
         term_sel <= DSFL_TERM_NONE;
      end else if (apply) begin
         case (cmd_mode)
            DSFL_MODE_PDOWN: begin
               power_down <= 1'b1;
               term_sel <= dsfl_term_e'(cmd_sel);
            end
            DSFL_MODE_LOAD_UPD, DSFL_MODE_BOTH: begin
               // any output update wakes the converter
               power_down <= 1'b0;
               term_sel <= DSFL_TERM_NONE;
            end
            default: begin
            end
         endcase
      end
   end

   // frame counters
   logic [15:0] frames_r;
   logic [15:0] aborts_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frames_r <= `DSFL_CNT_RESET;
      end else if (commit_evt) begin
         frames_r <= frames_r + 16'h0001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aborts_r <= `DSFL_CNT_RESET;
      end else if (abort_evt) begin
         aborts_r <= aborts_r + 16'h0001;
      end
   end

   // ahb-lite slave, zero wait states
   logic ap_valid;
   logic dp_write_r;
   logic [7:0] dp_addr_r;
   logic [7:0] ap_addr;
   logic ctrl_wr;
   logic [31:0] rd_nxt;
   logic [31:0] status_word;

   assign ap_valid = hsel && htrans[1] && hready;
   assign ap_addr = haddr[7:0];
   assign ctrl_wr = dp_write_r && (dp_addr_r == `DSFL_OFS_CTRL);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write_r <= 1'b0;
         dp_addr_r <= 8'h00;
      end else if (hready) begin
         dp_write_r <= ap_valid && hwrite && (hsize == 3'h2) && (haddr[31:8] == 24'h000000);
         dp_addr_r <= ap_addr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_en_r <= `DSFL_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_en_r <= hwdata[`DSFL_CTRL_EN_BIT];
      end
   end

   always_comb begin
      status_word = 32'h00000000;
      status_word[`DSFL_ST_PD_BIT] = power_down;
      status_word[`DSFL_ST_TERM_HI:`DSFL_ST_TERM_LO] = term_sel;
      status_word[`DSFL_ST_VALID_BIT] = valid_seen_r;
      status_word[`DSFL_ST_EN_BIT] = ctrl_en_r;
   end

   // a control register read right behind a control write sees the new value
   always_comb begin
      rd_nxt = 32'h00000000;
      case (ap_addr)
         `DSFL_OFS_CTRL: begin
            rd_nxt[`DSFL_CTRL_EN_BIT] = ctrl_wr ? hwdata[`DSFL_CTRL_EN_BIT] : ctrl_en_r;
         end
         `DSFL_OFS_STATUS: rd_nxt = status_word;
         `DSFL_OFS_OUT_A: rd_nxt[9:0] = channel_a_output;
         `DSFL_OFS_OUT_B: rd_nxt[9:0] = channel_b_output;
         `DSFL_OFS_IN_A: rd_nxt[9:0] = in_a_r;
         `DSFL_OFS_IN_B: rd_nxt[9:0] = in_b_r;
         `DSFL_OFS_LAST: rd_nxt[15:0] = last_word_r;
         `DSFL_OFS_FRAMES: rd_nxt[15:0] = frames_r;
         `DSFL_OFS_ABORTS: rd_nxt[15:0] = aborts_r;
         default: rd_nxt = 32'h00000000;
      endcase
      if (haddr[31:8] != 24'h000000) begin
         rd_nxt = 32'h00000000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (ap_valid && !hwrite) begin
         hrdata <= rd_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

endmodule // dsfl_top

/* File: dsfl_top_asserts.sv */
`include "dsfl_regs.svh"

module dsfl_top_asserts
   import dsfl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sync_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire dsfl_code_t channel_a_output,
   input wire dsfl_code_t channel_b_output,
   input wire logic power_down,
   input wire dsfl_term_e term_sel
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   wire logic rd = hsel & htrans[1] & hready & ~hwrite;

   a_reset_zero: assert property ($rose(hresetn) |->
      channel_a_output == 10'h000 && channel_b_output == 10'h000 && !power_down)
      else $error("outputs not zero after reset");
   a_pd_term_set: assert property (power_down |-> term_sel != DSFL_TERM_NONE)
      else $error("power down without termination");
   a_idle_hold_a: assert property (sync_n [*6] ##1 sync_n |-> $stable(channel_a_output))
      else $error("channel a moved without a frame");
   a_idle_hold_b: assert property (sync_n [*6] ##1 sync_n |-> $stable(channel_b_output))
      else $error("channel b moved without a frame");
   a_idle_hold_pd: assert property (sync_n [*6] ##1 sync_n |-> $stable(power_down))
      else $error("power down moved without a frame");
   a_read_out_a: assert property (rd && haddr == {24'h0, `DSFL_OFS_OUT_A} |=>
      hrdata == {22'h0, $past(channel_a_output)})
      else $error("channel a read mismatch");
   a_read_out_b: assert property (rd && haddr == {24'h0, `DSFL_OFS_OUT_B} |=>
      hrdata == {22'h0, $past(channel_b_output)})
      else $error("channel b read mismatch");
   a_read_pd_bits: assert property (rd && haddr == {24'h0, `DSFL_OFS_STATUS} |=>
      hrdata[2:0] == {$past(term_sel), $past(power_down)})
      else $error("status power down bits mismatch");
endmodule // dsfl_top_asserts

bind dsfl_top dsfl_top_asserts u_chk (
   .hclk(hclk), .hresetn(hresetn), .sync_n(sync_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .channel_a_output(channel_a_output),
   .channel_b_output(channel_b_output), .power_down(power_down), .term_sel(term_sel)
);

/* File: dsfl_host_model.sv */
module dsfl_host_model (
   output logic sclk,
   output logic sync_n,
   output logic din
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      din = 1'b0;
   end

   // clock stands high between frames; bits past 16 are random filler
   task automatic send(input logic [15:0] w, input int n);
      int i;
      sync_n = 1'b0;
      for (i = 0; i < n; i++) begin
         din = (i < 16) ? w[15 - i] : 1'($urandom);
         #62.5 sclk = 1'b0;
         #62.5 sclk = 1'b1;
      end
      sync_n = 1'b1;
      din = ~din;
      #250;
   endtask
endmodule // dsfl_host_model

/* File: tb_top.sv */
`include "dsfl_regs.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk, hresetn, hsel, hwrite, rd_ph, epd, en_e;
   logic [31:0] haddr, hwdata;
   logic [1:0] htrans, et, s, m;
   logic [2:0] hsize;
   logic [9:0] ea, eb, d;
   logic [22:0] prev_o;
   logic [22:0] oq[$];
   logic [31:0] rq[$];
   int n_errors, total_checks, i;
   wire logic hready, hreadyout, hresp, sclk, sync_n, din, pd;
   wire logic [31:0] hrdata;
   wire logic [9:0] ca, cb;
   wire logic [1:0] ts;
   wire logic [22:0] cur_o = {ca, cb, pd, ts};

   assign hready = hreadyout;
   dsfl_host_model u_host (.sclk(sclk), .sync_n(sync_n), .din(din));
   dsfl_top u_dut (
      .hclk(hclk), .hresetn(hresetn), .sclk(sclk), .sync_n(sync_n), .din(din),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .channel_a_output(ca), .channel_b_output(cb),
      .power_down(pd), .term_sel(ts)
   );

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // read: dd is the expected data
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] dd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= dd;
      rd_ph <= !w;
      if (!w) rq.push_back(dd);
      do @(posedge hclk); while (hready !== 1'b1);
      rd_ph <= 1'b0;
   endtask

   // expected outputs are noted before the frame goes out
   task automatic frame(input logic [1:0] fs, fm, input logic [9:0] fd, input int n);
      logic [22:0] old;
      old = {ea, eb, epd, et};
      if (n >= 16 && en_e) begin
         if (fm == 2'h1 && fs < 2) begin
            if (fs == `DSFL_SEL_A) ea = fd;
            else eb = fd;
            epd = 1'b0;
         end
         if (fm == 2'h2) begin
            ea = fd;
            eb = fd;
            epd = 1'b0;
         end
         if (fm == 2'h3 && fs != 2'h0) begin
            epd = 1'b1;
            et = fs;
         end
      end
      if (old[22:2] != {ea, eb, epd} || (epd && old[1:0] != et)) oq.push_back({ea, eb, epd, et});
      u_host.send({fs, fm, fd, 2'($urandom)}, n);
   endtask

   always @(posedge hclk) begin
      if (rd_ph === 1'b1 && hready === 1'b1) begin
         chk(hrdata === rq.pop_front() && hresp === 1'b0, "read data");
      end
   end

   always @(posedge hclk) begin
      if (hresetn === 1'b1 && cur_o !== prev_o) begin
         if (oq.size() == 0) chk(1'b0, "unexpected output change");
         else chk(cur_o[22:2] === oq[0][22:2] && (!oq[0][2] || cur_o[1:0] === oq[0][1:0]),
                  "outputs");
         if (oq.size() != 0) void'(oq.pop_front());
      end
      prev_o <= cur_o;
   end

   initial begin
      #300us;
      n_errors++;
      print_verdict();
   end

   initial begin
      {hresetn, hsel, hwrite, rd_ph, epd, haddr, hwdata, htrans, et, ea, eb} = '0;
      hsize = 3'h2;
      en_e = 1'b1;
      prev_o = '0;
      n_errors = 0;
      total_checks = 0;
      void'($urandom(86120));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(cur_o === 23'h0, "reset outputs");
      bus(1'b0, 32'h04, 32'h10);
      bus(1'b0, 32'h00, 32'h1);
      bus(1'b0, 32'h40, 32'h0);
      frame(2'h0, 2'h0, 10'h155, 16);
      frame(2'h0, 2'h1, 10'h2AA, 9);
      frame(2'h1, 2'h1, 10'h3FF, 15);
      bus(1'b0, 32'h08, 32'h0);
      bus(1'b0, 32'h10, 32'h155);
      bus(1'b0, 32'h1C, 32'h1);
      bus(1'b0, 32'h20, 32'h1);
      $display("test reset and abort done");
      for (i = 0; i < 8; i++) begin
         s = 2'($urandom_range(1));
         m = 2'($urandom_range(2, 1));
         d = 10'($urandom);
         frame(s, m, d, 16);
         bus(1'b0, 32'h08, {22'h0, ea});
         bus(1'b0, 32'h0C, {22'h0, eb});
      end
      frame(2'h0, 2'h1, 10'h0F0, 20);
      frame(2'h1, 2'h1, 10'h30F, 16);
      $display("test channel updates done");
      for (i = 0; i < 4; i++) frame(2'(i), 2'h3, 10'h000, 16);
      bus(1'b0, 32'h04, {27'h0, 2'h3, et, 1'b1});
      frame(2'h2, 2'h1, 10'h111, 16);
      frame(2'h0, 2'h2, 10'h222, 16);
      $display("test power down done");
      bus(1'b1, 32'h00, 32'h0);
      en_e = 1'b0;
      bus(1'b0, 32'h00, 32'h0);
      frame(2'h0, 2'h1, 10'h333, 16);
      bus(1'b1, 32'h00, 32'h1);
      en_e = 1'b1;
      $display("test enable done");
      hresetn <= 1'b0;
      {ea, eb, epd, et} = '0;
      repeat (2) @(posedge hclk);
      chk(cur_o === 23'h0, "mid reset outputs");
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      frame(2'h1, 2'h1, 10'h2C3, 16);
      bus(1'b0, 32'h0C, 32'h2C3);
      chk(oq.size() == 0, "expected output change never seen");
      $display("test second reset done");
      print_verdict();
   end
endmodule // tb_top
